// ---- design/status_reg.sv ----
// Status register bank of a serial flash: two status bytes, write gates,
// write enable latch, error flag and a serial shifter for status reads.
// Assumes a command decoder on the same clock supplies one-cycle strobes.
//
// Contract
// (R1) Byte two bits 7..5 read zero
// (R2) Reset command enable, cleared at power-up
// (R3) Lockdown command enable, default off
// (R4) Program suspend flag read-only
// (R5) Erase suspend flag read-only
// (R6) Busy flag shows internal operation
// (R7) Byte two write changes bits 4,3 only
// (R8) Lock set blocks all protection changes
// (R9) Lock clear allows protection changes
// (R10) Lock cleared at power-up, kept on reset
// (R11) Protect pin asserted: lock only sets
// (R12) Byte one write changes lock only
// (R13) Error flag set on failed bytes
// (R14) Aborted operations never set error
// (R15) Error refreshed after each erase/program
// (R16) Pin level shown as status bit
// (R17) Summary reports none, some, all
// (R18) Latch clear rejects protected commands
// (R19) Latch cleared at power-up and reset
// (R20) Latch cleared on completion or abort
// (R21) Latch kept on partial opcode abort
// (R22) Summary at bits 3:2, codes fixed
// (R23) Pin level bit four, zero asserted
// (R24) Byte one bit layout, six zero
// (R25) Status shifted out MSB first, fresh
// (R26) Suspend flags follow suspend state
`timescale 1ns/1ps
`default_nettype none
module status_reg
  import status_reg_pkg::*;
#(
  parameter int unsigned NUM_SECTORS = status_reg_pkg::SECTORS
)(
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   reset_n,
  // Pin input (raw, asynchronous)
  input  wire logic                   write_protect_n,
  // Command strobes from the decoder
  input  wire logic                   soft_reset_req,
  input  wire logic                   write_enable_cmd,
  input  wire logic                   write_disable_cmd,
  input  wire logic                   write_byte_one,
  input  wire logic                   write_byte_two,
  input  wire logic [7:0]             write_data,
  input  wire logic                   prot_cmd_done,
  input  wire logic                   prot_cmd_abort,
  input  wire logic                   partial_opcode_abort,
  input  wire logic                   hold_abort,
  input  wire logic                   sector_cmd_req,
  input  wire logic                   sector_cmd_protect,
  input  wire logic [4:0]             sector_index,
  input  wire logic                   global_cmd_req,
  input  wire logic                   global_cmd_protect,
  input  wire logic                   lockdown_frozen,
  // Core state
  input  wire logic                   busy_in,
  input  wire logic                   erprog_done,
  input  wire logic                   erprog_fail,
  input  wire logic                   program_suspend_enter,
  input  wire logic                   erase_suspend_enter,
  input  wire logic                   suspend_resume,
  // Serial status read
  input  wire logic                   shift_load_one,
  input  wire logic                   shift_load_two,
  input  wire logic                   shift_step,
  output logic                        serial_out,
  // Status outputs
  output logic [7:0]                  status_byte_one,
  output logic [7:0]                  status_byte_two,
  output logic                        reset_cmd_allowed,
  output logic                        lockdown_cmd_allowed,
  output logic                        write_enable_latch,
  output logic [NUM_SECTORS-1:0]      sector_protect
);
  import status_reg_pkg::*;

  // ==========================================================
  // Pin synchroniser
  logic       wp_s1;
  logic       wp_s2;
  logic       wp_s3;
  logic       wp_level;   // Filtered pin level, 0 = asserted
  logic       protection_regs_lock;
  logic       erase_program_error;
  logic       reset_cmd_enable;
  logic       lockdown_cmd_enable;
  logic       program_suspend_flag;
  logic       erase_suspend_flag;
  logic [1:0] soft_protect_summary;
  logic [7:0] next_byte_one;
  logic [7:0] next_byte_two;
  logic [7:0] shifter;

  // Three-stage capture; change accepted once stages two and three agree
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wp_s1    <= 1'b1;
      wp_s2    <= 1'b1;
      wp_s3    <= 1'b1;
      wp_level <= 1'b1;
    end
    else
    begin
      wp_s1 <= write_protect_n;
      wp_s2 <= wp_s1;
      wp_s3 <= wp_s2;
      if (wp_s2 == wp_s3)
        wp_level <= wp_s3; // R16
    end
  end

  // ==========================================================
  // Protection lock
  // Lock follows byte-one writes, gated by latch and protect pin
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      protection_regs_lock <= LOCK_RESET; // R10
    else if (write_byte_one && write_enable_latch) // R18
    begin
      if (wp_level || write_data[B1_LOCK_BIT]) // R11
        protection_regs_lock <= write_data[B1_LOCK_BIT]; // R12
    end
  end

  // ==========================================================
  // Sector protection registers
  // Updated only while unlocked; start fully protected
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      sector_protect <= '1;
    else if (!protection_regs_lock && write_enable_latch) // R8 R9
    begin
      if (sector_cmd_req)
        sector_protect[sector_index] <= sector_cmd_protect;
      else if (global_cmd_req)
        sector_protect <= {NUM_SECTORS{global_cmd_protect}};
    end
  end

  // Summary code from sector registers
  always_comb
  begin
    if (&sector_protect)
      soft_protect_summary = SWP_ALL; // R17 R22
    else if (|sector_protect)
      soft_protect_summary = SWP_SOME;
    else
      soft_protect_summary = SWP_NONE;
  end

  // ==========================================================
  // Write enable latch
  // Set by write enable; cleared by completions, protection and hold aborts, soft reset; kept on partial opcode abort
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      write_enable_latch <= WEL_RESET; // R19
    else if (soft_reset_req && reset_cmd_enable)
      write_enable_latch <= 1'b0; // R19
    else if (write_disable_cmd || prot_cmd_done || prot_cmd_abort || hold_abort
             || ((write_byte_one || write_byte_two) && write_enable_latch))
      write_enable_latch <= 1'b0; // R20
    else if (partial_opcode_abort)
      write_enable_latch <= write_enable_latch; // R21
    else if (write_enable_cmd)
      write_enable_latch <= 1'b1;
  end

  // ==========================================================
  // Second byte enables
  // Only bits 4 and 3 are writable; freeze locks lockdown enable low
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reset_cmd_enable    <= RESET_CMD_ENABLE_RESET; // R2
      lockdown_cmd_enable <= SLE_RESET; // R3
    end
    else
    begin
      if (write_byte_two && write_enable_latch) // R7 R18
        reset_cmd_enable <= write_data[B2_RESET_CMD_ENABLE_BIT];
      if (lockdown_frozen)
        lockdown_cmd_enable <= 1'b0;
      else if (write_byte_two && write_enable_latch)
        lockdown_cmd_enable <= write_data[B2_SLE_BIT]; // R3
    end
  end

  // ==========================================================
  // Error and suspend flags
  // Error refreshed on every real completion; aborts give no done
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      erase_program_error <= EPE_RESET;
    else if (erprog_done)
      erase_program_error <= erprog_fail; // R13 R14 R15
  end

  // Suspend flags set on entry, cleared on resume
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      program_suspend_flag <= 1'b0;
      erase_suspend_flag   <= 1'b0;
    end
    else
    begin
      // Entry wins over a resume in the same cycle
      if (program_suspend_enter)
        program_suspend_flag <= 1'b1; // R4 R26
      else if (suspend_resume)
        program_suspend_flag <= 1'b0; // R26
      if (erase_suspend_enter)
        erase_suspend_flag <= 1'b1; // R5 R26
      else if (suspend_resume)
        erase_suspend_flag <= 1'b0; // R26
    end
  end

  // ==========================================================
  // Byte assembly
  always_comb
  begin
    next_byte_one = 8'h00; // R24
    next_byte_one[B1_LOCK_BIT] = protection_regs_lock;
    next_byte_one[B1_EPE_BIT] = erase_program_error;
    next_byte_one[B1_WPP_BIT] = wp_level; // R23
    next_byte_one[B1_SWP_HI:B1_SWP_LO] = soft_protect_summary; // R22
    next_byte_one[B1_WEL_BIT] = write_enable_latch;
    next_byte_one[B1_BUSY_BIT] = busy_in; // R6
    next_byte_two = 8'h00; // R1
    next_byte_two[B2_RESET_CMD_ENABLE_BIT] = reset_cmd_enable;
    next_byte_two[B2_SLE_BIT] = lockdown_cmd_enable;
    next_byte_two[B2_PS_BIT] = program_suspend_flag;
    next_byte_two[B2_ES_BIT] = erase_suspend_flag;
    next_byte_two[B2_BUSY_BIT] = busy_in; // R6
  end

  // Registered status view and enables
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      status_byte_one      <= 8'h0c;
      status_byte_two      <= 8'h00;
      reset_cmd_allowed    <= 1'b0;
      lockdown_cmd_allowed <= 1'b0;
    end
    else
    begin
      status_byte_one      <= next_byte_one;
      status_byte_two      <= next_byte_two;
      reset_cmd_allowed    <= reset_cmd_enable; // R2
      lockdown_cmd_allowed <= lockdown_cmd_enable && write_enable_latch; // R3 R18
    end
  end

  // ==========================================================
  // Serial shifter: fresh snapshot per byte, MSB first
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shifter    <= 8'h00;
      serial_out <= 1'b0;
    end
    else if (shift_load_one || shift_load_two)
    begin
      shifter    <= {(shift_load_one ? next_byte_one[6:0] : next_byte_two[6:0]), 1'b0}; // R25
      serial_out <= shift_load_one ? next_byte_one[7] : next_byte_two[7];
    end
    else if (shift_step)
    begin
      serial_out <= shifter[7];
      shifter    <= {shifter[6:0], 1'b0};
    end
  end

  // ==========================================================
  // Assertions
  a_byte_two_rsvd: assert property (@(posedge clock) disable iff (!reset_n)
    status_byte_two[7:5] == 3'h0) else $error("reserved bits nonzero"); // R1
  a_byte_one_rsvd: assert property (@(posedge clock) disable iff (!reset_n)
    !status_byte_one[B1_RSVD_BIT]) else $error("byte one bit six set"); // R24
  a_lock_wp_hold: assert property (@(posedge clock) disable iff (!reset_n)
    (!wp_level && protection_regs_lock) |=> protection_regs_lock)
    else $error("lock cleared under protect pin"); // R11
  a_sector_locked: assert property (@(posedge clock) disable iff (!reset_n)
    protection_regs_lock |=> $stable(sector_protect))
    else $error("sectors changed while locked"); // R8
  a_epe_refresh: assert property (@(posedge clock) disable iff (!reset_n)
    erprog_done |=> erase_program_error == $past(erprog_fail))
    else $error("error flag not refreshed"); // R15
  a_wel_clear: assert property (@(posedge clock) disable iff (!reset_n)
    (prot_cmd_done || prot_cmd_abort || hold_abort) |=> !write_enable_latch)
    else $error("latch not cleared"); // R20
  a_busy_view: assert property (@(posedge clock) disable iff (!reset_n)
    busy_in |=> status_byte_one[B1_BUSY_BIT] && status_byte_two[B2_BUSY_BIT])
    else $error("busy not shown"); // R6
  a_summary_code: assert property (@(posedge clock) disable iff (!reset_n)
    ##1 status_byte_one[3:2] != SWP_RESERVED)
    else $error("reserved summary code"); // R22
  a_reset_cmd_enable_gate: assert property (@(posedge clock) disable iff (!reset_n)
    (write_byte_two && !write_enable_latch) |=> $stable(reset_cmd_enable))
    else $error("enable changed without latch"); // R18
  c_lock_set: cover property (@(posedge clock) disable iff (!reset_n)
    $rose(protection_regs_lock));
  c_epe_set: cover property (@(posedge clock) disable iff (!reset_n)
    $rose(erase_program_error));
  c_suspend: cover property (@(posedge clock) disable iff (!reset_n)
    $rose(erase_suspend_flag));
endmodule : status_reg
`default_nettype wire

// ---- include/status_reg_pkg.sv ----
// Status register package: bit positions, codes and reset values.
// Assumes a single 25 MHz clock domain in the consumer.
package status_reg_pkg;
  // First status byte fields
  localparam int unsigned B1_LOCK_BIT  = 7;
  localparam int unsigned B1_RSVD_BIT  = 6;
  localparam int unsigned B1_EPE_BIT   = 5;
  localparam int unsigned B1_WPP_BIT   = 4;
  localparam int unsigned B1_SWP_HI    = 3;
  localparam int unsigned B1_SWP_LO    = 2;
  localparam int unsigned B1_WEL_BIT   = 1;
  localparam int unsigned B1_BUSY_BIT  = 0;
  // Second status byte fields
  localparam int unsigned B2_RESET_CMD_ENABLE_BIT  = 4;
  localparam int unsigned B2_SLE_BIT   = 3;
  localparam int unsigned B2_PS_BIT    = 2;
  localparam int unsigned B2_ES_BIT    = 1;
  localparam int unsigned B2_BUSY_BIT  = 0;
  // Software protection summary codes
  localparam logic [1:0] SWP_NONE     = 2'h0;
  localparam logic [1:0] SWP_SOME     = 2'h1;
  localparam logic [1:0] SWP_RESERVED = 2'h2;
  localparam logic [1:0] SWP_ALL      = 2'h3;
  // Reset values
  localparam logic       LOCK_RESET   = 1'b0;
  localparam logic       WEL_RESET    = 1'b0;
  localparam logic       RESET_CMD_ENABLE_RESET   = 1'b0;
  localparam logic       SLE_RESET    = 1'b0;
  localparam logic       EPE_RESET    = 1'b0;
  localparam int unsigned SECTORS     = 32;
  localparam int unsigned BYTE_BITS   = 8;
endpackage : status_reg_pkg

// ---- design/unused_placeholder_removed.sv ----
// Intentionally empty companion: all logic lives in status_reg.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- bench/host_model.sv ----
// Host command model: drives one-cycle command strobes and their argument.
// Assumes the block samples strobes on the rising edge of clock.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input  wire logic        clock,
  // Command strobes and argument
  output var  logic [17:0] strobe,
  output var  logic [7:0]  cmd_arg
);
  // Idle host
  initial
  begin
    strobe = 18'h0_0000;
    cmd_arg = 8'h00;
  end
  // One strobe for exactly one cycle, launched off the falling edge
  task automatic issue(input int idx, input logic [7:0] arg);
    @(negedge clock);
    cmd_arg = arg;
    strobe[idx] = 1'b1;
    @(negedge clock);
    strobe = 18'h0_0000;
    cmd_arg = ~arg; // Stale argument is not held
  endtask : issue
endmodule : host_model
`default_nettype wire

// ---- bench/status_reg_test.sv ----
// Testbench for the status register bank driven by a host command model.
// Assumes the package and host_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module status_reg_test;
  import status_reg_pkg::*;
  // Strobe positions in the host model
  localparam int RST = 0, WEN = 1, WDIS = 2, WB1 = 3, WB2 = 4, PDONE = 5, PABORT = 6;
  localparam int PART = 7, HOLD = 8, SECT = 9, GLOB = 10, EPDONE = 11, PSUS = 12;
  localparam int ESUS = 13, RESUME = 14, LD1 = 15, LD2 = 16, STEP = 17;
  logic        clock, reset_n, write_protect_n, busy_in, lockdown_frozen, serial_out;
  logic        reset_cmd_allowed, lockdown_cmd_allowed, write_enable_latch;
  logic [17:0] strobe;
  logic [7:0]  cmd_arg, status_byte_one, status_byte_two;
  logic [31:0] sector_protect;
  int          failures = 0;
  int          checked = 0;
  // Host side and device under test
  host_model i_host_model (.clock(clock), .strobe(strobe), .cmd_arg(cmd_arg));
  status_reg i_status_reg (
    .clock(clock), .reset_n(reset_n), .write_protect_n(write_protect_n),
    .soft_reset_req(strobe[RST]), .write_enable_cmd(strobe[WEN]),
    .write_disable_cmd(strobe[WDIS]), .write_byte_one(strobe[WB1]),
    .write_byte_two(strobe[WB2]), .write_data(cmd_arg), .prot_cmd_done(strobe[PDONE]),
    .prot_cmd_abort(strobe[PABORT]), .partial_opcode_abort(strobe[PART]),
    .hold_abort(strobe[HOLD]), .sector_cmd_req(strobe[SECT]),
    .sector_cmd_protect(cmd_arg[7]), .sector_index(cmd_arg[4:0]),
    .global_cmd_req(strobe[GLOB]), .global_cmd_protect(cmd_arg[7]),
    .lockdown_frozen(lockdown_frozen), .busy_in(busy_in), .erprog_done(strobe[EPDONE]),
    .erprog_fail(cmd_arg[0]), .program_suspend_enter(strobe[PSUS]),
    .erase_suspend_enter(strobe[ESUS]), .suspend_resume(strobe[RESUME]),
    .shift_load_one(strobe[LD1]), .shift_load_two(strobe[LD2]), .shift_step(strobe[STEP]),
    .serial_out(serial_out), .status_byte_one(status_byte_one),
    .status_byte_two(status_byte_two), .reset_cmd_allowed(reset_cmd_allowed),
    .lockdown_cmd_allowed(lockdown_cmd_allowed), .write_enable_latch(write_enable_latch),
    .sector_protect(sector_protect));
  // Compare one result
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Issue one command and let the status bytes settle
  task automatic cmd(input int idx, input logic [7:0] arg = 8'h00);
    i_host_model.issue(idx, arg);
    repeat (2) @(negedge clock);
  endtask : cmd
  // Report and end the run
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  // 25 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Hang guard
  initial
  begin
    #400000;
    failures++;
    finish_test();
  end
  // Main sequence
  initial
  begin
    reset_n = 1'b0;
    write_protect_n = 1'b1;
    busy_in = 1'b0;
    lockdown_frozen = 1'b0;
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    repeat (6) @(negedge clock);
    check("byte one", 8'h1c, status_byte_one);
    check("byte two", 8'h00, status_byte_two);
    cmd(WB2, 8'hff);
    check("byte two", 8'h00, status_byte_two);
    cmd(WEN);
    check("byte one", 8'h1e, status_byte_one);
    cmd(WB2, 8'hff);
    check("byte two", 8'h18, status_byte_two);
    check("latch", 1'b0, write_enable_latch);
    check("reset allowed", 1'b1, reset_cmd_allowed);
    cmd(WEN);
    check("lockdown allowed", 1'b1, lockdown_cmd_allowed);
    lockdown_frozen = 1'b1;
    repeat (3) @(negedge clock);
    check("byte two", 8'h10, status_byte_two);
    cmd(PART);
    check("latch", 1'b1, write_enable_latch);
    cmd(HOLD);
    check("latch", 1'b0, write_enable_latch);
    cmd(WEN);
    cmd(WDIS);
    check("latch", 1'b0, write_enable_latch);
    cmd(WEN);
    cmd(PABORT);
    check("byte one", 8'h1c, status_byte_one);
    cmd(WEN);
    cmd(SECT, 8'h03);
    check("sectors", 32'hffff_fff7, sector_protect);
    check("byte one", 8'h14, status_byte_one & 8'hfd);
    cmd(WEN);
    cmd(GLOB, 8'h00);
    check("byte one", 8'h10, status_byte_one & 8'hfd);
    cmd(WEN);
    cmd(GLOB, 8'h80);
    check("byte one", 8'h1c, status_byte_one & 8'hfd);
    cmd(WEN);
    cmd(WB1, 8'hff);
    check("byte one", 8'h9c, status_byte_one);
    cmd(WEN);
    cmd(SECT, 8'h05);
    cmd(WEN);
    cmd(GLOB, 8'h00);
    check("sectors", 32'hffff_ffff, sector_protect);
    write_protect_n = 1'b0;
    repeat (6) @(negedge clock);
    check("byte one", 8'h8c, status_byte_one & 8'hfd);
    cmd(WEN);
    cmd(WB1, 8'h00);
    check("byte one", 8'h8c, status_byte_one);
    cmd(WEN);
    cmd(RST);
    check("latch", 1'b0, write_enable_latch);
    check("byte one", 8'h8c, status_byte_one);
    write_protect_n = 1'b1;
    repeat (6) @(negedge clock);
    cmd(WEN);
    cmd(WB1, 8'h00);
    check("byte one", 8'h1c, status_byte_one);
    cmd(EPDONE, 8'h01);
    check("byte one", 8'h3c, status_byte_one);
    cmd(EPDONE, 8'h00);
    check("byte one", 8'h1c, status_byte_one);
    busy_in = 1'b1;
    cmd(PSUS);
    check("byte two", 8'h15, status_byte_two);
    check("byte one", 8'h1d, status_byte_one);
    cmd(ESUS);
    check("byte two", 8'h17, status_byte_two);
    cmd(RESUME);
    check("byte two", 8'h11, status_byte_two);
    // Byte two shifted while busy, byte one after busy drops: fresh snapshot each
    cmd(LD2);
    check("serial bit", 1'b0, serial_out);
    for (int i = 6; i >= 0; i--)
    begin
      cmd(STEP);
      check("serial bit", 8'h11 >> i & 8'h01, serial_out);
    end
    busy_in = 1'b0;
    cmd(LD1);
    check("serial bit", 1'b0, serial_out);
    for (int i = 6; i >= 0; i--)
    begin
      cmd(STEP);
      check("serial bit", 8'h1c >> i & 8'h01, serial_out);
    end
    // Completion clears the latch; reset command ignored once disabled
    cmd(WEN);
    cmd(PDONE);
    check("latch", 1'b0, write_enable_latch);
    cmd(WEN);
    cmd(WB2, 8'h00);
    check("reset allowed", 1'b0, reset_cmd_allowed);
    cmd(WEN);
    cmd(RST);
    check("latch", 1'b1, write_enable_latch);
    finish_test();
  end
endmodule : status_reg_test
`default_nettype wire
